// [design/card_powerup_ocr.sv]
// What this block does
// (R01) Host gives at least 74 clocks with command high before commands.
// (R02) After any power-up the card sits idle without a go-idle command.
// (R03) Newer hosts send the interface-condition command and check voltage.
// (R04) Hosts lacking that command supply only the high voltage range.
// (R05) Host repeats operating-condition negotiation until power-up finishes.
// (R06) With several cards the host checks all, else initializes one.
// (R07) Data lines 1-3 stay inputs until a bus-width command enables them.
// (R08) Line 3 pull-up is on at power-up; host removes it later.
// (R09) In SDIO mode line 1 may signal interrupts outside data transfers.
// (R10) In SDIO mode line 2 may serve as read-wait.
// (R11) Registers reachable only through commands; no driver-stage register.
// (R12) All reserved register bits read as zero.
// (R13) Card holds a 32-bit operating-conditions word.
// (R14) Bit 7 reads 0 unless a dual-voltage card saw interface-condition.
// (R15) Bit 31 low while power-up routine runs, set once finished.
// (R16) Bit 30 gives capacity, valid only once bit 31 is set.
// (R17) Host reads capacity bit after power-up completes.
// (R18) Bits 15-23 each flag one 0.1 V range from 2.7 V to 3.6 V.
// (R19) Bit 24 flags accepted 1.8 V switching, only on capable cards.
// (R20) Each negotiation reply carries the current operating-conditions word.
`default_nettype none
module card_powerup_ocr #(
	parameter int POWERUP_CYCLES = card_powerup_pkg::POWERUP_CYCLES
) (
	input  wire logic                         clk_sys_in,
	input  wire logic                         rst_b_in,
	input  wire logic                         sd_clk_in,
	input  wire logic                         cmd_in,
	output var  logic                         cmd_out,
	output var  logic                         cmd_oe_out,
	input  wire card_powerup_pkg::config_type strap_in,
	input  wire logic                         sdio_mode_in,
	input  wire logic                         data_busy_in,
	input  wire logic                         sdio_irq_in,
	input  wire logic                         read_wait_in,
	output var  logic                         data_line_1_out,
	output var  logic                         data_line_1_oe_out,
	output var  logic                         data_line_2_out,
	output var  logic                         data_line_2_oe_out,
	output var  logic                         wide_bus_out,
	output var  logic                         detect_data_line_3_pullup_out,
	output var  logic                         powered_up_out
);
	localparam logic [31:0] PWR_LAST = 32'(POWERUP_CYCLES - 1);

	logic [1:0]                          sys_rst_sync;
	logic                                sys_rst_b;
	logic [1:0]                          link_rst_sync;
	logic                                link_rst_b;
	card_powerup_pkg::config_type        straps;
	logic                                strap_done;
	logic [card_powerup_pkg::EVT_COUNT-1:0] evt_s1, evt_s2, evt_s3, evt_s4;
	logic [card_powerup_pkg::EVT_COUNT-1:0] sys_evt, link_evt_tgl, evt;
	logic [1:0]                          val_s1, val_s2;
	logic                                init_started;
	logic [31:0]                         pwr_cnt;
	logic [12:0]                         stat_s1, stat_s2;
	card_powerup_pkg::config_type        link_cfg;
	logic                                link_ready;
	logic                                cmd_s1, cmd_s2;
	card_powerup_pkg::link_state_type    link_state;
	logic [5:0]                          bit_cnt;
	logic [1:0]                          gap_cnt;
	logic [46:0]                         rx_shift;
	logic [46:0]                         next_frame;
	logic [47:0]                         tx_shift, tx_frame;
	card_powerup_pkg::command_type       rx_cmd;
	logic                                frame_end, frame_done;
	logic [31:0]                         op_cond_word, resp_payload;
	logic [8:0]                          host_win;
	logic                                resp_valid, resp_r3, next_app;
	logic                                set_cmd8, app_cmd, cmd8_seen;
	logic                                set_cd_val, wide_val;
	logic [39:0]                         resp_body;

	// Checksum of short responses, x^7 + x^3 + 1
	function automatic logic [6:0] crc7(input logic [39:0] bits);
		logic [6:0] c;
		logic       fb;
		c = 7'h00;
		for (int i = 39; i >= 0; i--) begin
			fb = bits[i] ^ c[6];
			c = {c[5:0], 1'b0};
			if (fb) begin
				c = c ^ card_powerup_pkg::CRC7_POLY;
			end
		end
		return c;
	endfunction

	// System reset released through two flops
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sys_rst_sync <= 2'b00;
		end else begin
			sys_rst_sync <= {sys_rst_sync[0], 1'b1};
		end
	end
	assign sys_rst_b = sys_rst_sync[1];

	// (R01) needs host clocks
	// Link reset released on the card clock; the host's idle clocks finish it
	always_ff @(posedge sd_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			link_rst_sync <= 2'b00;
		end else begin
			link_rst_sync <= {link_rst_sync[0], 1'b1};
		end
	end
	assign link_rst_b = link_rst_sync[1];

	// (R13) profile straps captured
	// Straps caught once after release, then frozen
	always_ff @(posedge clk_sys_in or negedge sys_rst_b) begin
		if (!sys_rst_b) begin
			straps <= '0;
			strap_done <= 1'b0;
		end else if (!strap_done) begin
			straps <= strap_in;
			strap_done <= 1'b1;
		end
	end

	// Event toggles and their values into the system domain
	always_ff @(posedge clk_sys_in or negedge sys_rst_b) begin
		if (!sys_rst_b) begin
			evt_s1 <= '0;
			evt_s2 <= '0;
			evt_s3 <= '0;
			evt_s4 <= '0;
			val_s1 <= 2'b10;
			val_s2 <= 2'b10;
		end else begin
			evt_s1 <= link_evt_tgl;
			evt_s2 <= evt_s1;
			evt_s3 <= evt_s2;
			evt_s4 <= evt_s3;
			val_s1 <= {set_cd_val, wide_val};
			val_s2 <= val_s1;
		end
	end
	// Edge taken one stage late so values have settled first
	assign sys_evt = evt_s3 ^ evt_s4;

	// (R02) idle at power-up
	// (R15) busy until routine ends
	always_ff @(posedge clk_sys_in or negedge sys_rst_b) begin
		if (!sys_rst_b) begin
			init_started <= 1'b0;
			pwr_cnt <= 32'h0000_0000;
			powered_up_out <= 1'b0;
		end else if (sys_evt[card_powerup_pkg::EVT_IDLE]) begin
			init_started <= 1'b0;
			pwr_cnt <= 32'h0000_0000;
			powered_up_out <= 1'b0;
		end else begin
			if (sys_evt[card_powerup_pkg::EVT_OP_COND]) begin
				init_started <= 1'b1;
			end
			if (init_started && !powered_up_out) begin
				if (pwr_cnt == PWR_LAST) begin
					powered_up_out <= 1'b1;
				end else begin
					pwr_cnt <= pwr_cnt + 32'h0000_0001;
				end
			end
		end
	end

	// (R08) pull-up until cleared
	// (R07) narrow bus until set
	always_ff @(posedge clk_sys_in or negedge sys_rst_b) begin
		if (!sys_rst_b) begin
			detect_data_line_3_pullup_out <= 1'b1;
			wide_bus_out <= 1'b0;
		end else if (sys_evt[card_powerup_pkg::EVT_IDLE]) begin
			detect_data_line_3_pullup_out <= 1'b1;
			wide_bus_out <= 1'b0;
		end else begin
			if (sys_evt[card_powerup_pkg::EVT_SET_CD]) begin
				detect_data_line_3_pullup_out <= val_s2[1];
			end
			if (sys_evt[card_powerup_pkg::EVT_WIDTH]) begin
				wide_bus_out <= val_s2[0];
			end
		end
	end

	// (R09) interrupt on line 1
	// (R10) read-wait on line 2
	// Both pull low only; lines 1-2 stay inputs in narrow mode
	always_ff @(posedge clk_sys_in or negedge sys_rst_b) begin
		if (!sys_rst_b) begin
			data_line_1_out <= 1'b0;
			data_line_1_oe_out <= 1'b0;
			data_line_2_out <= 1'b0;
			data_line_2_oe_out <= 1'b0;
		end else begin
			data_line_1_out <= 1'b0;
			data_line_1_oe_out <= sdio_mode_in && wide_bus_out &&
				!data_busy_in && sdio_irq_in;
			data_line_2_out <= 1'b0;
			data_line_2_oe_out <= sdio_mode_in && wide_bus_out &&
				read_wait_in;
		end
	end

	// Status into the link domain; straps are static after capture
	always_ff @(posedge sd_clk_in or negedge link_rst_b) begin
		if (!link_rst_b) begin
			stat_s1 <= '0;
			stat_s2 <= '0;
			cmd_s1 <= 1'b1;
			cmd_s2 <= 1'b1;
		end else begin
			stat_s1 <= {powered_up_out, straps};
			stat_s2 <= stat_s1;
			cmd_s1 <= cmd_in;
			cmd_s2 <= cmd_s1;
		end
	end
	assign link_ready = stat_s2[12];
	assign link_cfg = stat_s2[11:0];

	// Command decode and reply selection
	always_comb begin
		next_frame = {rx_shift[45:0], cmd_s2};
		rx_cmd = next_frame[45:8];
		frame_end = (link_state == card_powerup_pkg::LINK_RECV) &&
			(bit_cnt == card_powerup_pkg::FRAME_LAST);
		frame_done = frame_end && next_frame[46] && next_frame[0];
		host_win = rx_cmd.arg[card_powerup_pkg::WIN_MSB:
			card_powerup_pkg::WIN_LSB];
		// (R12) reserved bits zero
		op_cond_word = card_powerup_pkg::OPC_RESET;
		// (R18) voltage window bits
		op_cond_word[card_powerup_pkg::WIN_MSB:card_powerup_pkg::WIN_LSB] =
			link_cfg.window;
		// (R14) low voltage bit
		op_cond_word[card_powerup_pkg::LOW_VOLT_BIT] =
			cmd8_seen && link_cfg.dual_voltage;
		// (R16) capacity after ready
		op_cond_word[card_powerup_pkg::BUSY_BIT] = link_ready;
		op_cond_word[card_powerup_pkg::CAP_STATUS_BIT] =
			link_ready && link_cfg.high_capacity;
		// (R19) switch accepted bit
		op_cond_word[card_powerup_pkg::LV_SWITCH_BIT] = link_ready &&
			link_cfg.uhs_capable && rx_cmd.arg[card_powerup_pkg::ARG_LV_REQ_BIT];
		resp_payload = 32'h0000_0000;
		resp_payload[card_powerup_pkg::STATE_LSB +: 4] = link_ready ?
			card_powerup_pkg::STATE_READY : card_powerup_pkg::STATE_IDLE;
		resp_payload[card_powerup_pkg::APP_CMD_BIT] = app_cmd;
		resp_valid = 1'b0;
		resp_r3 = 1'b0;
		next_app = 1'b0;
		set_cmd8 = 1'b0;
		evt = '0;
		if (app_cmd) begin
			case (rx_cmd.index)
				// (R05) negotiation reply
				// (R20) reply carries word
				card_powerup_pkg::ACMD_OP_COND: begin
					if (host_win == 9'h000 ||
						(host_win & link_cfg.window) != 9'h000) begin
						resp_valid = 1'b1;
						resp_r3 = 1'b1;
						resp_payload = op_cond_word;
						evt[card_powerup_pkg::EVT_OP_COND] = host_win != 9'h000;
					end
				end
				card_powerup_pkg::ACMD_SET_CD: begin
					resp_valid = 1'b1;
					evt[card_powerup_pkg::EVT_SET_CD] = 1'b1;
				end
				card_powerup_pkg::ACMD_BUS_WIDTH: begin
					resp_valid = 1'b1;
					evt[card_powerup_pkg::EVT_WIDTH] = 1'b1;
				end
				default: begin
				end
			endcase
		end else begin
			case (rx_cmd.index)
				card_powerup_pkg::CMD_GO_IDLE: begin
					evt[card_powerup_pkg::EVT_IDLE] = 1'b1;
				end
				card_powerup_pkg::CMD_APP: begin
					resp_valid = 1'b1;
					next_app = 1'b1;
					resp_payload[card_powerup_pkg::APP_CMD_BIT] = 1'b1;
				end
				// (R03) voltage check reply
				card_powerup_pkg::CMD_IF_COND: begin
					if (rx_cmd.arg[11:8] == card_powerup_pkg::IF_VOLT_HIGH) begin
						resp_valid = 1'b1;
						set_cmd8 = 1'b1;
						resp_payload = {20'h0_0000, rx_cmd.arg[11:0]};
					end
				end
				default: begin
				end
			endcase
		end
		resp_body = {2'b00, resp_r3 ? card_powerup_pkg::R3_INDEX :
			rx_cmd.index, resp_payload};
		tx_frame = {resp_body, resp_r3 ? card_powerup_pkg::R3_CRC :
			crc7(resp_body), 1'b1};
	end

	// (R11) command-only access
	// Frame receive, reply gap and reply shift-out
	always_ff @(posedge sd_clk_in or negedge link_rst_b) begin
		if (!link_rst_b) begin
			link_state <= card_powerup_pkg::LINK_IDLE;
			bit_cnt <= 6'h00;
			gap_cnt <= 2'h0;
			rx_shift <= '0;
			tx_shift <= '0;
			cmd_out <= 1'b1;
			cmd_oe_out <= 1'b0;
		end else begin
			case (link_state)
				card_powerup_pkg::LINK_IDLE: begin
					if (gap_cnt != 2'h0) begin
						gap_cnt <= gap_cnt - 2'h1;
					end else if (!cmd_s2) begin
						link_state <= card_powerup_pkg::LINK_RECV;
						bit_cnt <= 6'h00;
					end
				end
				card_powerup_pkg::LINK_RECV: begin
					rx_shift <= next_frame[46:0];
					if (frame_end) begin
						if (frame_done && resp_valid) begin
							link_state <= card_powerup_pkg::LINK_GAP;
							gap_cnt <= card_powerup_pkg::RESP_GAP;
							tx_shift <= tx_frame;
						end else begin
							link_state <= card_powerup_pkg::LINK_IDLE;
						end
					end else begin
						bit_cnt <= bit_cnt + 6'h01;
					end
				end
				card_powerup_pkg::LINK_GAP: begin
					if (gap_cnt == 2'h1) begin
						link_state <= card_powerup_pkg::LINK_SEND;
						cmd_oe_out <= 1'b1;
						cmd_out <= tx_shift[47];
						tx_shift <= {tx_shift[46:0], 1'b1};
						bit_cnt <= 6'h01;
					end else begin
						gap_cnt <= gap_cnt - 2'h1;
					end
				end
				card_powerup_pkg::LINK_SEND: begin
					if (bit_cnt == card_powerup_pkg::FRAME_BITS) begin
						// Hold off so our own echo is not seen as a start
						link_state <= card_powerup_pkg::LINK_IDLE;
						cmd_oe_out <= 1'b0;
						cmd_out <= 1'b1;
						gap_cnt <= card_powerup_pkg::TURN_HOLD;
					end else begin
						cmd_out <= tx_shift[47];
						tx_shift <= {tx_shift[46:0], 1'b1};
						bit_cnt <= bit_cnt + 6'h01;
					end
				end
				default: begin
					link_state <= card_powerup_pkg::LINK_IDLE;
				end
			endcase
		end
	end

	// (R14) interface condition latch
	// Per-command card state and events toward the system side
	always_ff @(posedge sd_clk_in or negedge link_rst_b) begin
		if (!link_rst_b) begin
			app_cmd <= 1'b0;
			cmd8_seen <= 1'b0;
			link_evt_tgl <= '0;
			set_cd_val <= 1'b1;
			wide_val <= 1'b0;
		end else if (frame_done) begin
			app_cmd <= next_app;
			link_evt_tgl <= link_evt_tgl ^ evt;
			if (evt[card_powerup_pkg::EVT_IDLE]) begin
				cmd8_seen <= 1'b0;
			end else if (set_cmd8) begin
				cmd8_seen <= 1'b1;
			end
			if (evt[card_powerup_pkg::EVT_SET_CD]) begin
				set_cd_val <= rx_cmd.arg[0];
			end
			if (evt[card_powerup_pkg::EVT_WIDTH]) begin
				wide_val <= rx_cmd.arg[1:0] == card_powerup_pkg::WIDTH_4BIT;
			end
		end
	end

	sequence r3_header_s;
		!cmd_out ##1 !cmd_out ##1 cmd_out [*6];
	endsequence
	sequence reply_start_s;
		$rose(cmd_oe_out) ##0 r3_header_s;
	endsequence

	idle_start_a: assert property (@(posedge clk_sys_in) // (R02)
		$rose(sys_rst_b) |-> !powered_up_out &&
		detect_data_line_3_pullup_out && !wide_bus_out)
		else $error("card not idle after reset");
	powerup_time_a: assert property (@(posedge clk_sys_in) // (R15)
		disable iff (!sys_rst_b)
		$rose(powered_up_out) |-> $past(pwr_cnt) == PWR_LAST)
		else $error("power-up finished at wrong count");
	pullup_drop_a: assert property (@(posedge clk_sys_in) // (R08)
		disable iff (!sys_rst_b)
		$fell(detect_data_line_3_pullup_out) |->
		$past(sys_evt[card_powerup_pkg::EVT_SET_CD]) && !$past(val_s2[1]))
		else $error("pull-up removed without command");
	narrow_bus_a: assert property (@(posedge clk_sys_in) // (R07)
		disable iff (!sys_rst_b)
		!wide_bus_out |=> !data_line_1_oe_out && !data_line_2_oe_out)
		else $error("data line driven in narrow mode");
	irq_line_a: assert property (@(posedge clk_sys_in) // (R09)
		disable iff (!sys_rst_b)
		data_line_1_oe_out |-> !$past(data_busy_in) && $past(sdio_mode_in))
		else $error("interrupt driven during transfer");
	read_wait_a: assert property (@(posedge clk_sys_in) // (R10)
		disable iff (!sys_rst_b)
		$rose(data_line_2_oe_out) |-> $past(read_wait_in))
		else $error("read-wait without request");
	reserved_zero_a: assert property (@(posedge sd_clk_in) // (R12)
		disable iff (!link_rst_b)
		(op_cond_word & card_powerup_pkg::OPC_RESERVED_MASK) == 32'h0000_0000)
		else $error("reserved bit set");
	low_volt_a: assert property (@(posedge sd_clk_in) // (R14)
		disable iff (!link_rst_b)
		$rose(cmd8_seen) |-> $past(frame_done) && $past(set_cmd8))
		else $error("interface flag set without its command");
	busy_status_a: assert property (@(posedge sd_clk_in) // (R16)
		disable iff (!link_rst_b)
		!op_cond_word[card_powerup_pkg::BUSY_BIT] |->
		!op_cond_word[card_powerup_pkg::CAP_STATUS_BIT] &&
		!op_cond_word[card_powerup_pkg::LV_SWITCH_BIT])
		else $error("status bit shown while busy");
	reply_timing_a: assert property (@(posedge sd_clk_in) // (R20)
		disable iff (!link_rst_b)
		frame_done && resp_r3 |-> ##3 reply_start_s)
		else $error("negotiation reply late or malformed");
	reply_length_a: assert property (@(posedge sd_clk_in) // (R05)
		disable iff (!link_rst_b)
		$rose(cmd_oe_out) |-> ##47 (cmd_oe_out && cmd_out) ##1 !cmd_oe_out)
		else $error("reply not 48 bits");
endmodule
`default_nettype wire

// [common/card_powerup_pkg.sv]
`default_nettype none
package card_powerup_pkg;
	// Operating conditions word layout
	localparam int LOW_VOLT_BIT   = 7;
	localparam int WIN_LSB        = 15;
	localparam int WIN_MSB        = 23;
	localparam int LV_SWITCH_BIT  = 24;
	localparam int CAP_STATUS_BIT = 30;
	localparam int BUSY_BIT       = 31;
	localparam logic [31:0] OPC_RESERVED_MASK = 32'h3E00_7F7F;
	localparam logic [31:0] OPC_RESET         = 32'h0000_0000;
	// Command indices
	localparam logic [5:0] CMD_GO_IDLE    = 6'h00;
	localparam logic [5:0] CMD_IF_COND    = 6'h08;
	localparam logic [5:0] CMD_APP        = 6'h37;
	localparam logic [5:0] ACMD_BUS_WIDTH = 6'h06;
	localparam logic [5:0] ACMD_OP_COND   = 6'h29;
	localparam logic [5:0] ACMD_SET_CD    = 6'h2A;
	// Negotiation reply framing without a checksum; checksum polynomial of other replies
	localparam logic [5:0] R3_INDEX  = 6'h3F;
	localparam logic [6:0] R3_CRC    = 7'h7F;
	localparam logic [6:0] CRC7_POLY = 7'h09;
	// Argument fields
	localparam int         ARG_LV_REQ_BIT = 24;
	localparam logic [3:0] IF_VOLT_HIGH   = 4'h1;
	localparam logic [1:0] WIDTH_4BIT     = 2'h2;
	// Card status fields of short responses
	localparam int         APP_CMD_BIT = 5;
	localparam int         STATE_LSB   = 9;
	localparam logic [3:0] STATE_IDLE  = 4'h0;
	localparam logic [3:0] STATE_READY = 4'h1;
	// Frame timing in link clocks
	localparam logic [5:0] FRAME_LAST = 6'h2E;
	localparam logic [5:0] FRAME_BITS = 6'h30;
	localparam logic [1:0] RESP_GAP   = 2'h2;
	localparam logic [1:0] TURN_HOLD  = 2'h3;
	// Internal power-up routine length
	localparam int CLK_SYS_HZ      = 10_000_000;
	localparam int POWERUP_TIME_US = 1000;
	localparam int POWERUP_CYCLES  =
		POWERUP_TIME_US * (CLK_SYS_HZ / 1_000_000);
	// Event toggles from link to system domain
	localparam int EVT_IDLE    = 0;
	localparam int EVT_OP_COND = 1;
	localparam int EVT_SET_CD  = 2;
	localparam int EVT_WIDTH   = 3;
	localparam int EVT_COUNT   = 4;

	typedef struct packed {
		logic [8:0] window;
		logic       high_capacity;
		logic       dual_voltage;
		logic       uhs_capable;
	} config_type;

	typedef struct packed {
		logic [5:0]  index;
		logic [31:0] arg;
	} command_type;

	typedef enum logic [1:0] {
		LINK_IDLE = 2'b00,
		LINK_RECV = 2'b01,
		LINK_GAP  = 2'b10,
		LINK_SEND = 2'b11
	} link_state_type;
endpackage
`default_nettype wire

// [tb/sd_host_model.sv]
`default_nettype none
module sd_host_model (
	output var  logic sd_clk_out,
	output var  logic cmd_drv_out,
	output var  logic cmd_oe_out,
	input  wire logic cmd_line_in
);
	timeunit 1ns;
	timeprecision 100ps;

	// Clock parked low, line left to its pull-up
	initial begin
		sd_clk_out  = 1'b0;
		cmd_drv_out = 1'b1;
		cmd_oe_out  = 1'b0;
	end

	// Frame checksum, x^7+x^3+1 from zero
	function automatic logic [6:0] crc7(input logic [39:0] d);
		logic [6:0] c;
		c = 7'h00;
		for (int i = 39; i >= 0; i--) begin
			c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
		end
		return c;
	endfunction

	// One bus clock: drive after the rise, sample late in the cycle
	task automatic tick(input logic oe, input logic b, output logic s);
		sd_clk_out = 1'b1;
		#1 cmd_oe_out = oe;
		cmd_drv_out = b;
		#6.5 sd_clk_out = 1'b0;
		#7 s = cmd_line_in;
		#0.5;
	endtask

	task automatic idle(input int n);
		logic s;
		repeat (n) tick(1'b0, 1'b1, s);
	endtask

	// whole frames with checksum; gap is -1 on silence
	task automatic command(input logic [5:0] idx, input logic [31:0] arg,
		output logic [47:0] rsp, output int gap);
		logic [47:0] fr;
		logic        s;
		fr  = {2'b01, idx, arg, crc7({2'b01, idx, arg}), 1'b1};
		gap = -1;
		rsp = 48'hFFFF_FFFF_FFFF;
		for (int i = 47; i >= 0; i--) tick(1'b1, fr[i], s);
		// Bounded wait keeps a silent card from hanging the run
		for (int k = 0; k < 40 && gap < 0; k++) begin
			tick(1'b0, 1'b1, s);
			if (s === 1'b0) gap = k;
		end
		if (gap >= 0) begin
			rsp[47] = 1'b0;
			for (int i = 46; i >= 0; i--) begin
				tick(1'b0, 1'b1, s);
				rsp[i] = s;
			end
		end
		// Spacing before the next start bit
		idle(8);
	endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int          PUC = 20;
	localparam logic [47:0] ALL = 48'hFFFF_FFFF_FFFF;
	localparam logic [47:0] M55 = 48'hFF00_001E_2001;

	logic                         clk, rst_b, sd_clk, cmd_line;
	logic                         cmd_out, cmd_oe, host_cmd, host_oe;
	logic                         sdio, dbusy, irq, rwait;
	logic                         dl1, dl1_oe, dl2, dl2_oe;
	logic                         wide, pull, pwr, if_seen, up, rdy;
	card_powerup_pkg::config_type strap;
	int                           mismatches, checked, gap;
	logic [31:0]                  seed, x, a;
	logic [39:0]                  f;
	logic [47:0]                  rsp;

	// System clock, 100 ns
	initial clk = 1'b0;
	always #50 clk = ~clk;

	// Command wire with its pull-up
	assign cmd_line = cmd_oe ? cmd_out : (host_oe ? host_cmd : 1'b1);

	card_powerup_ocr #(.POWERUP_CYCLES(PUC)) u_card_powerup_ocr (
		.clk_sys_in                   (clk),
		.rst_b_in                     (rst_b),
		.sd_clk_in                    (sd_clk),
		.cmd_in                       (cmd_line),
		.cmd_out                      (cmd_out),
		.cmd_oe_out                   (cmd_oe),
		.strap_in                     (strap),
		.sdio_mode_in                 (sdio),
		.data_busy_in                 (dbusy),
		.sdio_irq_in                  (irq),
		.read_wait_in                 (rwait),
		.data_line_1_out              (dl1),
		.data_line_1_oe_out           (dl1_oe),
		.data_line_2_out              (dl2),
		.data_line_2_oe_out           (dl2_oe),
		.wide_bus_out                 (wide),
		.detect_data_line_3_pullup_out(pull),
		.powered_up_out               (pwr)
	);

	sd_host_model u_sd_host_model (
		.sd_clk_out (sd_clk),
		.cmd_drv_out(host_cmd),
		.cmd_oe_out (host_oe),
		.cmd_line_in(cmd_line)
	);

	// Fixed-seed xorshift
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Expected word from the bench's own view of the card
	function automatic logic [47:0] r3(input logic a24);
		logic [31:0] w;
		w        = 32'h0000_0000;
		w[23:15] = strap.window;
		w[7]     = if_seen & strap.dual_voltage;
		w[31]    = up;
		w[30]    = up & strap.high_capacity;
		w[24]    = up & strap.uhs_capable & a24;
		return {2'b00, card_powerup_pkg::R3_INDEX, w,
			card_powerup_pkg::R3_CRC, 1'b1};
	endfunction

	// Short status reply: state field and app flag
	function automatic logic [47:0] st(input logic [5:0] i);
		return {2'b00, i, 19'h0_0000, 4'(rdy), 3'h0, 1'b1, 12'h000, 1'b1};
	endfunction

	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One command; want low means the card must stay silent
	task automatic cmd(input logic [5:0] i, input logic [31:0] v,
		input logic [47:0] e, input logic [47:0] m, input logic want);
		u_sd_host_model.command(i, v, rsp, gap);
		if (want) begin
			chk(rsp & m, e & m);
			chk(48'(gap), 48'h0000_0000_0004);
		end else begin
			chk(48'(gap), ALL);
		end
	endtask

	task automatic acmd(input logic [5:0] i, input logic [31:0] v,
		input logic [47:0] e, input logic [47:0] m, input logic want);
		cmd(card_powerup_pkg::CMD_APP, 32'h0000_0000,
			st(card_powerup_pkg::CMD_APP), M55, 1'b1);
		cmd(i, v, e, m, want);
	endtask

	// Side effects cross domains, so poll with a bound
	task automatic outs(input logic [2:0] e);
		for (int k = 0; k < 80 && {wide, pull, pwr} !== e; k++) begin
			@(posedge clk);
			#5;
		end
		chk(48'({wide, pull, pwr}), 48'(e));
	endtask

	task automatic dl(input logic b, input logic [1:0] e);
		@(posedge clk);
		#5 dbusy = b;
		repeat (3) @(posedge clk);
		#5 chk(48'({dl1_oe, dl2_oe, dl1, dl2}), 48'({e, 2'b00}));
	endtask

	// New straps under reset, idle clocks after the release
	task automatic power_up();
		@(posedge clk);
		#5 rst_b = 1'b0;
		x     = xs();
		strap = {1'b0, x[7:1], 1'b1, x[8], x[9], x[10]};
		{up, rdy, if_seen} = 3'b000;
		repeat (8) @(posedge clk);
		#5 rst_b = 1'b1;
		// Idle clocks counted from release, which stands for supply up
		u_sd_host_model.idle(80);
	endtask

	task automatic give_verdict();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Two power cycles, the second one in mid-run
	initial begin
		{rst_b, dbusy, sdio, irq, rwait} = 5'b00111;
		strap      = '0;
		seed       = 32'h3431;
		mismatches = 0;
		checked    = 0;
		for (int it = 0; it < 2; it++) begin
			power_up();
			outs(3'b010);
			dl(1'b0, 2'b00);
			if (it == 1) begin
				cmd(card_powerup_pkg::CMD_IF_COND, 32'h0000_02AA, ALL, ALL, 1'b0);
				f = {2'b00, card_powerup_pkg::CMD_IF_COND, 32'h0000_01AA};
				cmd(card_powerup_pkg::CMD_IF_COND, 32'h0000_01AA,
					{f, u_sd_host_model.crc7(f), 1'b1}, ALL, 1'b1);
				if_seen = 1'b1;
			end
			x = xs();
			a = {7'h00, x[9], x[8:0] | strap.window, 15'h0000};
			acmd(card_powerup_pkg::ACMD_OP_COND, 32'h0000_0000, r3(1'b0), ALL, 1'b1);
			acmd(card_powerup_pkg::ACMD_OP_COND, {8'h00, ~strap.window, 15'h0000},
				ALL, ALL, 1'b0);
			acmd(card_powerup_pkg::ACMD_OP_COND, a, r3(a[24]), ALL, 1'b1);
			// Status field follows the power-up bit at once
			{up, rdy} = 2'b11;
			outs(3'b011);
			acmd(card_powerup_pkg::ACMD_OP_COND, a, r3(a[24]), ALL, 1'b1);
			acmd(card_powerup_pkg::ACMD_SET_CD, 32'h0000_0000,
				st(card_powerup_pkg::ACMD_SET_CD), M55, 1'b1);
			outs(3'b001);
			acmd(card_powerup_pkg::ACMD_BUS_WIDTH, 32'h0000_0002,
				st(card_powerup_pkg::ACMD_BUS_WIDTH), M55, 1'b1);
			outs(3'b101);
			dl(1'b0, 2'b11);
			dl(1'b1, 2'b01);
			sdio = 1'b0;
			dl(1'b0, 2'b00);
			sdio = 1'b1;
			cmd(card_powerup_pkg::ACMD_OP_COND, a, ALL, ALL, 1'b0);
			cmd(card_powerup_pkg::CMD_GO_IDLE, 32'h0000_0000, ALL, ALL, 1'b0);
			{up, rdy, if_seen} = 3'b000;
			outs(3'b010);
			acmd(card_powerup_pkg::ACMD_OP_COND, a, r3(a[24]), ALL, 1'b1);
			$display("test %0d done, checked %0d", it, checked);
		end
		give_verdict();
	end
endmodule
`default_nettype wire
